// ===== core/acc_comparator_control.sv
// Analog comparator control, event flag and routing logic
`timescale 1ns/1ps
module acc_comparator_control (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic [7:0] i_data_addr,
  input  wire logic       i_data_wr,
  input  wire logic       i_data_rd,
  input  wire logic [5:0] i_io_addr,
  input  wire logic       i_io_wr,
  input  wire logic       i_io_rd,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  output logic            o_rdata_valid,
  input  wire logic       i_cpu_global_irq,
  input  wire logic       i_irq_vector_ack,
  input  wire logic       i_negative_mux_enable,
  input  wire logic       i_converter_on,
  input  wire logic [2:0] i_channel_select_low,
  input  wire logic       i_comparator_raw,
  input  wire logic       i_positive_pin_digital,
  input  wire logic       i_negative_pin_digital,
  output logic            o_comparator_power_off,
  output logic            o_bandgap_positive_select,
  output logic            o_negative_use_channel,
  output logic      [2:0] o_negative_channel,
  output logic            o_irq_request,
  output logic            o_capture_input,
  output logic            o_positive_pin_buffer_off,
  output logic            o_negative_pin_buffer_off,
  output logic            o_positive_pin_value,
  output logic            o_negative_pin_value
);
  import acc_pkg::*;

  logic [7:0] ctrl_reg, ctrl_next;
  logic [1:0] dis_reg, dis_next;
  logic       sync1_reg, sync2_reg, prev_reg;
  logic       sync1_next, sync2_next, prev_next;
  logic       sel_ctrl, sel_dis, wr_ctrl, wr_dis, rd_ctrl, rd_dis;
  logic       event_hit;
  logic [7:0] rdata_next;
  logic       rvalid_next;
  logic [7:0] rdata_reg;
  logic       rvalid_reg;

  always_comb begin
    wr_ctrl = (i_data_wr && i_data_addr == ACC_CTRL_DATA_ADDR) ||
              (i_io_wr && i_io_addr == ACC_CTRL_IO_ADDR);
    rd_ctrl = (i_data_rd && i_data_addr == ACC_CTRL_DATA_ADDR) ||
              (i_io_rd && i_io_addr == ACC_CTRL_IO_ADDR);
    wr_dis  = i_data_wr && i_data_addr == ACC_DIS_DATA_ADDR;
    rd_dis  = i_data_rd && i_data_addr == ACC_DIS_DATA_ADDR;
    sel_ctrl = wr_ctrl || rd_ctrl;
    sel_dis  = wr_dis || rd_dis;
  end

  // Synchroniser; sync2 and prev stages hold while powered off (sync1 keeps sampling) so no spurious edges appear
  always_comb begin
    sync1_next = i_comparator_raw;
    sync2_next = sync2_reg;
    prev_next  = prev_reg;
    if (!ctrl_reg[ACC_B_OFF]) begin
      sync2_next = sync1_reg;
      prev_next  = sync2_reg;
    end
  end

  always_comb begin
    case (ctrl_reg[1:0])
      ACC_MODE_TOGGLE: event_hit = sync2_reg != prev_reg;
      ACC_MODE_FALL:   event_hit = prev_reg && !sync2_reg;
      ACC_MODE_RISE:   event_hit = !prev_reg && sync2_reg;
      default:         event_hit = 1'b0;
    endcase
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    dis_next  = dis_reg;
    if (wr_ctrl) begin
      ctrl_next[ACC_B_OFF] = i_wdata[ACC_B_OFF];
      ctrl_next[ACC_B_BG]  = i_wdata[ACC_B_BG];
      ctrl_next[ACC_B_IE]  = i_wdata[ACC_B_IE];
      ctrl_next[ACC_B_CAP] = i_wdata[ACC_B_CAP];
      ctrl_next[1:0]       = i_wdata[1:0];
      if (i_wdata[ACC_B_FLAG])
        ctrl_next[ACC_B_FLAG] = 1'b0;
    end
    if (i_irq_vector_ack)
      ctrl_next[ACC_B_FLAG] = 1'b0;
    // Set wins over any clear in the same cycle
    if (event_hit)
      ctrl_next[ACC_B_FLAG] = 1'b1;
    ctrl_next[ACC_B_RES] = 1'b0;
    if (wr_dis)
      dis_next = i_wdata[1:0];
  end

  always_comb begin
    rvalid_next = sel_ctrl ? rd_ctrl : rd_dis;
    // Reserved bits of the disable register stay zero on read
    rdata_next  = 8'h00;
    if (rd_ctrl) begin
      rdata_next = ctrl_reg;
      rdata_next[ACC_B_RES] = sync2_reg;
    end else if (rd_dis) begin
      rdata_next[1:0] = dis_reg;
    end
    if (!sel_dis && !sel_ctrl)
      rvalid_next = 1'b0;
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_reg   <= ACC_CTRL_RESET;
      dis_reg    <= ACC_DIS_RESET;
      sync1_reg  <= 1'b0;
      sync2_reg  <= 1'b0;
      prev_reg   <= 1'b0;
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      dis_reg    <= dis_next;
      sync1_reg  <= sync1_next;
      sync2_reg  <= sync2_next;
      prev_reg   <= prev_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign o_rdata                   = rdata_reg;
  assign o_rdata_valid             = rvalid_reg;
  assign o_comparator_power_off    = ctrl_reg[ACC_B_OFF];
  assign o_bandgap_positive_select = ctrl_reg[ACC_B_BG];
  assign o_negative_use_channel = i_negative_mux_enable && !i_converter_on;
  assign o_negative_channel     = i_channel_select_low;
  assign o_irq_request = ctrl_reg[ACC_B_FLAG] && ctrl_reg[ACC_B_IE] &&
                         i_cpu_global_irq;
  assign o_capture_input = ctrl_reg[ACC_B_CAP] && sync2_reg;
  assign o_positive_pin_buffer_off = dis_reg[ACC_B_POSD];
  assign o_negative_pin_buffer_off = dis_reg[ACC_B_NEGD];
  assign o_positive_pin_value = i_positive_pin_digital && !dis_reg[ACC_B_POSD];
  assign o_negative_pin_value = i_negative_pin_digital && !dis_reg[ACC_B_NEGD];

  property p_flag_set;
    @(posedge i_sys_clk) disable iff (i_reset)
      event_hit |=> ctrl_reg[ACC_B_FLAG];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_irq;
    @(posedge i_sys_clk) disable iff (i_reset)
      o_irq_request == (ctrl_reg[ACC_B_FLAG] && ctrl_reg[ACC_B_IE] &&
                        i_cpu_global_irq);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_ack_clear;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_irq_vector_ack && !event_hit) |=> !ctrl_reg[ACC_B_FLAG];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack no clear");

  property p_w1c;
    @(posedge i_sys_clk) disable iff (i_reset)
      (wr_ctrl && i_wdata[ACC_B_FLAG] && !event_hit) |=>
        !ctrl_reg[ACC_B_FLAG];
  endproperty
  a_w1c: assert property (p_w1c) else $error("w1c failed");

  property p_w0_keep;
    @(posedge i_sys_clk) disable iff (i_reset)
      (ctrl_reg[ACC_B_FLAG] && !i_irq_vector_ack &&
       !(wr_ctrl && i_wdata[ACC_B_FLAG])) |=> ctrl_reg[ACC_B_FLAG];
  endproperty
  a_w0_keep: assert property (p_w0_keep) else $error("flag lost");

  property p_sync;
    @(posedge i_sys_clk) disable iff (i_reset)
      (!ctrl_reg[ACC_B_OFF] ##1 !ctrl_reg[ACC_B_OFF]) |->
        sync2_reg == $past(i_comparator_raw, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("sync latency");

  property p_hold_off;
    @(posedge i_sys_clk) disable iff (i_reset)
      ctrl_reg[ACC_B_OFF] |=> $stable(sync2_reg);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("moved off");

  property p_capture;
    @(posedge i_sys_clk) disable iff (i_reset)
      !ctrl_reg[ACC_B_CAP] |-> !o_capture_input;
  endproperty
  a_capture: assert property (p_capture) else $error("capture leak");

  property p_dis_read;
    @(posedge i_sys_clk) disable iff (i_reset)
      rd_dis |=> o_rdata[7:2] == 6'h00;
  endproperty
  a_dis_read: assert property (p_dis_read) else $error("reserved set");

  property p_pin_zero;
    @(posedge i_sys_clk) disable iff (i_reset)
      dis_reg[ACC_B_POSD] |-> !o_positive_pin_value;
  endproperty
  a_pin_zero: assert property (p_pin_zero) else $error("pin not zero");
endmodule : acc_comparator_control

// ===== pkg/acc_pkg.sv
// Constants and types for the analog comparator control block
// Function
// - Writing one to power-off bit switches the comparator off, any time.
// - Bandgap select one picks fixed reference; zero picks positive input pin.
// - Result bit reads comparator output through a synchroniser, 1-2 cycle delay.
// - Flag set when synchronised output event matches the selected mode.
// - Request raised only with flag, enable and global interrupt bit all set.
// - Flag cleared automatically when the comparator vector executes.
// - Writing one to flag clears it; writing zero leaves it.
// - Capture-route bit one feeds comparator output to timer capture input.
// - Mode 00 toggle, 01 reserved, 10 falling edge, 11 rising edge.
// - Control register at data offset 0x50, I/O address 0x30 (minus 0x20).
// - Input-disable bit turns off pin buffer; port input bit reads zero.
// - Bits 7:2 of input-disable register are reserved and read zero.
// - Raw result is one when positive input exceeds negative input.
// - Negative input is channel n when mux enabled and converter off.
package acc_pkg;
  localparam logic [7:0] ACC_CTRL_DATA_ADDR = 8'h50;
  localparam logic [7:0] ACC_IO_SHIFT       = 8'h20;
  localparam logic [5:0] ACC_CTRL_IO_ADDR   = 6'h30;
  localparam logic [7:0] ACC_DIS_DATA_ADDR  = 8'h7F;
  localparam int ACC_B_OFF   = 7;
  localparam int ACC_B_BG    = 6;
  localparam int ACC_B_RES   = 5;
  localparam int ACC_B_FLAG  = 4;
  localparam int ACC_B_IE    = 3;
  localparam int ACC_B_CAP   = 2;
  localparam int ACC_B_POSD  = 0;
  localparam int ACC_B_NEGD  = 1;
  localparam logic [1:0] ACC_MODE_TOGGLE = 2'h0;
  localparam logic [1:0] ACC_MODE_FALL   = 2'h2;
  localparam logic [1:0] ACC_MODE_RISE   = 2'h3;
  localparam logic [7:0] ACC_CTRL_RESET  = 8'h00;
  localparam logic [1:0] ACC_DIS_RESET   = 2'h0;
endpackage : acc_pkg

// ===== tb/acc_core_model.sv
// Behavioural model of the analog comparator core beside the control block
`timescale 1ns/1ps
module acc_core_model (
  input  wire logic       i_power_off,
  input  wire logic       i_bandgap_select,
  input  wire logic       i_use_channel,
  input  wire logic [7:0] i_pos_mv,
  input  wire logic [7:0] i_bg_mv,
  input  wire logic [7:0] i_neg_mv,
  input  wire logic [7:0] i_ch_mv,
  output logic            o_raw
);
  logic [7:0] plus_mv;
  logic [7:0] minus_mv;
  always_comb begin
    plus_mv  = i_bandgap_select ? i_bg_mv : i_pos_mv;
    minus_mv = i_use_channel ? i_ch_mv : i_neg_mv;
    // Unpowered core drives low, so a frozen high sync stage is visible
    o_raw = i_power_off ? 1'b0 : (plus_mv > minus_mv);
  end
endmodule : acc_core_model

// ===== tb/testbench.sv
// Self-checking bench for the analog comparator control block
`timescale 1ns/1ps
module testbench;
  import acc_pkg::*;
  logic i_sys_clk = 1'b0, i_reset = 1'b1, dwr = 0, drd = 0, iwr = 0, ird = 0;
  logic [7:0] daddr = 0, wdata = 0, rdata, pos = 0, bg = 8'h20, neg = 8'h64;
  logic [5:0] iaddr = 0;
  logic [2:0] chsel = 0, nch;
  logic gie = 0, ack = 0, mux = 0, conv = 0, pd = 0, nd = 0, raw, vld;
  logic off, bgs, usech, irq, cap, pbo, nbo, pv, nv;
  int num_errors = 0;
  int n_tests = 0;
  always #2.5 i_sys_clk = ~i_sys_clk;
  acc_comparator_control dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_data_addr(daddr), .i_data_wr(dwr), .i_data_rd(drd), .i_io_addr(iaddr),
    .i_io_wr(iwr), .i_io_rd(ird), .i_wdata(wdata), .o_rdata(rdata),
    .o_rdata_valid(vld), .i_cpu_global_irq(gie), .i_irq_vector_ack(ack),
    .i_negative_mux_enable(mux), .i_converter_on(conv),
    .i_channel_select_low(chsel), .i_comparator_raw(raw),
    .i_positive_pin_digital(pd), .i_negative_pin_digital(nd),
    .o_comparator_power_off(off), .o_bandgap_positive_select(bgs),
    .o_negative_use_channel(usech), .o_negative_channel(nch),
    .o_irq_request(irq), .o_capture_input(cap),
    .o_positive_pin_buffer_off(pbo), .o_negative_pin_buffer_off(nbo),
    .o_positive_pin_value(pv), .o_negative_pin_value(nv));
  acc_core_model core (.i_power_off(off), .i_bandgap_select(bgs),
    .i_use_channel(usech), .i_pos_mv(pos), .i_bg_mv(bg), .i_neg_mv(neg),
    .i_ch_mv(8'h10), .o_raw(raw));
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : tick
  task automatic wr(input logic io, input logic [7:0] a,
                    input logic [7:0] d);
    daddr = a; iaddr = a[5:0]; dwr = !io; iwr = io; wdata = d;
    tick(1);
    dwr = 0; iwr = 0;
  endtask : wr
  task automatic rd(input logic io, input logic [7:0] a, input logic v,
                    input logic [7:0] e);
    daddr = a; iaddr = a[5:0]; drd = !io; ird = io;
    tick(1);
    drd = 0; ird = 0;
    chk("valid", {7'h0, v}, {7'h0, vld});
    if (v) chk("rdata", e, rdata);
  endtask : rd
  task automatic t_regs;
    rd(0, ACC_CTRL_DATA_ADDR, 1, ACC_CTRL_RESET);
    rd(0, ACC_DIS_DATA_ADDR, 1, 8'h00);
    rd(0, 8'h51, 0, 8'h00);
    wr(1, {2'h0, ACC_CTRL_IO_ADDR}, 8'h67);
    rd(0, ACC_CTRL_DATA_ADDR, 1, 8'h47);
    chk("bandgap", 8'h01, {7'h0, bgs});
    wr(0, ACC_CTRL_DATA_ADDR, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      // Mode changes only while the interrupt enable is clear
      wr(0, ACC_CTRL_DATA_ADDR, 8'h10 | m[7:0]);
      pos = 8'hC8; tick(4);
      rd(0, ACC_CTRL_DATA_ADDR, 1,
         8'h20 | m[7:0] | ((m == 0 || m == 3) ? 8'h10 : 8'h00));
      wr(0, ACC_CTRL_DATA_ADDR, 8'h10 | m[7:0]);
      pos = 8'h00; tick(4);
      rd(0, ACC_CTRL_DATA_ADDR, 1, m[7:0] | ((m == 0 || m == 2) ? 8'h10 : 8'h00));
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_irq;
    wr(0, ACC_CTRL_DATA_ADDR, 8'h1B); gie = 1;
    pos = 8'hC8; tick(4);
    chk("irq", 8'h01, {7'h0, irq});
    gie = 0; tick(1);
    chk("irq gie off", 8'h00, {7'h0, irq});
    gie = 1; wr(0, ACC_CTRL_DATA_ADDR, 8'h03);
    chk("irq ie off", 8'h00, {7'h0, irq});
    wr(0, ACC_CTRL_DATA_ADDR, 8'h0B); ack = 1; tick(1); ack = 0;
    rd(0, ACC_CTRL_DATA_ADDR, 1, 8'h2B);
    wr(0, ACC_CTRL_DATA_ADDR, 8'h04); pos = 8'h00; tick(4);
    chk("capture low", 8'h00, {7'h0, cap});
    pos = 8'hC8; tick(4);
    chk("capture high", 8'h01, {7'h0, cap});
    wr(0, ACC_CTRL_DATA_ADDR, 8'h00);
    chk("capture off", 8'h00, {7'h0, cap});
    rd(0, ACC_CTRL_DATA_ADDR, 1, 8'h30);
    wr(0, ACC_CTRL_DATA_ADDR, 8'h90); tick(4);
    rd(0, ACC_CTRL_DATA_ADDR, 1, 8'hA0);
    wr(0, ACC_CTRL_DATA_ADDR, 8'h00);
    $display("test irq done");
  endtask : t_irq
  task automatic t_pins;
    pd = 1; nd = 1;
    wr(0, ACC_DIS_DATA_ADDR, 8'hFF);
    rd(0, ACC_DIS_DATA_ADDR, 1, 8'h03);
    chk("pins off", 8'h0C, {4'h0, nbo, pbo, nv, pv});
    wr(0, ACC_DIS_DATA_ADDR, 8'h01); tick(1);
    chk("pins part", 8'h06, {4'h0, nbo, pbo, nv, pv});
    for (int k = 0; k < 4; k++) begin
      mux = k[0]; conv = k[1]; chsel = k[2:0] + 3'h3; tick(1);
      chk("mux", {4'h0, k == 1, chsel}, {4'h0, usech, nch});
    end
    $display("test pins done");
  endtask : t_pins
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial begin
    #20000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    tick(6);
    i_reset = 0;
    t_regs();
    t_modes();
    t_irq();
    t_pins();
    report_and_stop();
  end
endmodule : testbench
